// ---- dv/pin_world.sv ----
// Far-side pin model: external drivers, pull-ups and floating pins
module pin_world (
	input wire aclk,
	input wire [7:0] pin_out, pin_oe, pullup_on, ext_drv, ext_en,
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt = 8'h55;
	// Undriven pins wander, so a stale level never passes as real
	always @(posedge aclk) flt <= ~flt;
	assign pin_in = (pin_oe & pin_out)
		| (~pin_oe & ext_en & ext_drv)
		| (~pin_oe & ~ext_en & (pullup_on | flt));
endmodule

// ---- dv/port_ctrl_props.sv ----
// Checker: bus and pin assertions on the port control block
module port_ctrl_props (
	input wire aclk, aresetn, clk_en, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
	input wire s_axi_arready, s_axi_awready, s_axi_wready, s_axi_rvalid, s_axi_rready,
	input wire [1:0] s_axi_bresp,
	input wire [31:0] s_axi_rdata,
	input wire [7:0] pin_out, pin_oe, pullup_on,
	input wire [5:0] serial_select, serial_out, serial_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	pu_gap_a: assert property (pullup_on[4:3] == 2'h0)
		else $error("pull-up on bit 3 or 4");
	ser_rel_a: assert property ((serial_select & ~serial_oe & pin_oe[5:0]) == 6'h0)
		else $error("serial pin driven");
	ser_lvl_a: assert property ((serial_select & pin_oe[5:0] & (pin_out[5:0] ^ serial_out)) == 6'h0)
		else $error("serial level wrong");
	rst_a: assert property (disable iff (1'h0) !aresetn |=> pin_oe == 8'h0 && pullup_on == 8'h0)
		else $error("pins after reset");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bresp dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata dropped");
	r_ans_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
		else $error("no read answer");
	b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready with bvalid");
endmodule
bind port_two_pin_control port_ctrl_props chk (.*);

// ---- dv/tb_top.sv ----
// Testbench: register access, pin readback and pull-up gating
`include "port_ctrl_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pin_in, pin_out, pin_oe, pullup_on, ext_drv = 8'h0, ext_en = 8'h0;
	logic [5:0] serial_select, serial_out = 6'h0, serial_oe = 6'h0;
	logic [11:0] ad [3] = '{`ADDR_PULLUP_ENABLE, `ADDR_FUNCTION_SELECT, `ADDR_OUTPUT_TYPE};
	logic [7:0] mk [3] = '{8'hE7, 8'h3F, 8'hE7};
	int err_count = 0, samples_checked = 0;
	port_two_pin_control uut (.*);
	pin_world far (.*);
	initial forever #5 aclk = ~aclk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= {a, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
	endtask
	// Pin changes need two synchroniser edges before readback
	task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		repeat (4) @(posedge aclk);
		s_axi_araddr <= {a, 2'b00};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, {24'h0, e});
		chk(s_axi_rresp, er);
	endtask
	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 3; i++) rd(ad[i], 8'h00, 2'h0);
		for (int i = 0; i < 3; i++) begin
			wr(ad[i], 8'hFF, 2'h0);
			rd(ad[i], mk[i], 2'h0);
		end
		wr(12'h100, 8'hFF, 2'h2);
		rd(12'h100, 8'h00, 2'h2);
		chk(serial_select, 32'h3F);
		$display("test 1 end");
		wr(`ADDR_FUNCTION_SELECT, 8'h00, 2'h0);
		ext_en <= 8'hFF;
		ext_drv <= 8'hA5;
		rd(`ADDR_LEVEL_READBACK, 8'hA5, 2'h0);
		chk(pullup_on, 32'hE7);
		ext_en <= 8'h00;
		wr(`ADDR_OUTPUT_LATCH, 8'hFF, 2'h0);
		wr(`ADDR_DIRECTION, 8'hFF, 2'h0);
		rd(`ADDR_LEVEL_READBACK, 8'hFF, 2'h0);
		chk(pin_oe, 32'h18);
		wr(`ADDR_OUTPUT_TYPE, 8'h00, 2'h0);
		rd(`ADDR_LEVEL_READBACK, 8'h18, 2'h0);
		chk(pullup_on, 32'h00);
		wr(`ADDR_OUTPUT_LATCH, 8'h00, 2'h0);
		wr(`ADDR_OUTPUT_TYPE, 8'hFF, 2'h0);
		chk({pin_oe, pin_out}, 32'hFF00);
		wr(`ADDR_DIRECTION, 8'h00, 2'h0);
		chk(pin_oe, 32'h00);
		$display("test 2 end");
		serial_oe <= 6'h3F;
		serial_out <= 6'h2A;
		wr(`ADDR_OUTPUT_TYPE, 8'h00, 2'h0);
		wr(`ADDR_DIRECTION, 8'hFF, 2'h0);
		wr(`ADDR_FUNCTION_SELECT, 8'hFF, 2'h0);
		chk({pin_oe[5:0], pin_out[5:0]}, 32'hFEA);
		wr(`ADDR_FUNCTION_SELECT, 8'h00, 2'h0);
		chk(pin_out, 32'h00);
		clk_en <= 1'h0;
		@(posedge aclk);
		chk({s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0);
		clk_en <= 1'h1;
		aresetn <= 1'h0;
		@(posedge aclk);
		aresetn <= 1'h1;
		rd(`ADDR_DIRECTION, 8'h00, 2'h0);
		$display("test 3 end");
		test_done;
	end
	initial begin
		#20000;
		err_count++;
		test_done;
	end
endmodule

// ---- verilog/port_ctrl_defines.vh ----
// Register map, reset values and bit masks for the eight-bit port control block
`ifndef PORT_CTRL_DEFINES_VH
`define PORT_CTRL_DEFINES_VH

// ==========================================================
// Register indices; a register's byte address is four times its index
`define ADDR_W 14
`define ADDR_OUTPUT_LATCH 12'h002
`define ADDR_LEVEL_READBACK 12'h00F
`define ADDR_DIRECTION 12'hF1C
`define ADDR_PULLUP_ENABLE 12'hF29
`define ADDR_FUNCTION_SELECT 12'hF36
`define ADDR_OUTPUT_TYPE 12'hF43

// ==========================================================
// Implemented bit masks and reset values
`define FUNC_MASK 8'h3F
`define OTYPE_MASK 8'hE7
`define PULLUP_MASK 8'hE7
`define DIR_MASK 8'hFF
`define LATCH_MASK 8'hFF
`define ALWAYS_READ_MASK 8'h18
`define REG_RESET 8'h00

// ==========================================================
// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/port_two_pin_control.v ----
// Eight-bit port control: function select, driver type, pull-up gating and pin readback
// Functional notes
// R1: On bits 0-5 a function-select bit of 0 gives the pin to the port, 1 to its serial unit.
// R2: On bits 0-2 and 5-7 output type 0 is push-pull and 1 is open-drain; bits 3-4 read zero.
// R3: The pull-up on bits 0-2, 5-7 connects only if enabled and the pin is input or open-drain; code uses the direction register, also for serial pins.
// R4: Readback on bits 0-2, 5-7 is the pin when input or open-drain output, 0 when push-pull; code uses the direction register, also for serial pins.
// R5: Readback on bits 3 and 4 is always the pin level.
// R6: In output mode a latch 0 drives low; 1 drives high, or releases the pin when open-drain.
// R7: Direction 0 is input, 1 is output; all bits reset to input.
// R8: Unimplemented bits of function, output-type and pull-up registers ignore writes, read 0.
`include "port_ctrl_defines.vh"

module port_two_pin_control (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [13:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [13:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] pin_in,
	output wire [7:0] pin_out,
	output wire [7:0] pin_oe,
	output wire [7:0] pullup_on,
	output wire [5:0] serial_select,
	input wire [5:0] serial_out,
	input wire [5:0] serial_oe
);

	// ==========================================================
	// Registers
	reg [7:0] output_latch_r;
	reg [7:0] direction_control_r;
	reg [7:0] pullup_enable_r;
	reg [7:0] function_select_r;
	reg [7:0] output_type_select_r;
	reg [7:0] pin_meta_r;
	reg [7:0] pin_sync_r;
	reg aw_held_r;
	reg w_held_r;
	reg [11:0] awaddr_r;
	reg [7:0] wdata_r;
	reg wlane_r;

	// ==========================================================
	// Pin synchroniser: two flops before any reader
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_r <= `REG_RESET;
			pin_sync_r <= `REG_RESET;
		end else if (clk_en) begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ==========================================================
	// Pin drive
	wire [7:0] func_full = {2'b00, function_select_r[5:0]};
	wire [7:0] ser_out_full = {2'b00, serial_out};
	wire [7:0] ser_oe_full = {2'b00, serial_oe};
	wire [7:0] port_level = (func_full & ser_out_full) | (~func_full & output_latch_r); // [R1]
	wire [7:0] port_drive = (func_full & ser_oe_full) | (~func_full & direction_control_r); // [R1] [R7]
	wire [7:0] open_drain = output_type_select_r & `OTYPE_MASK; // [R2]

	// Open-drain bits only ever drive low; a high releases the pin
	assign pin_out = port_level & ~open_drain; // [R6]
	assign pin_oe = port_drive & ~(open_drain & port_level); // [R6] [R2]
	assign serial_select = function_select_r[5:0]; // [R1]
	assign pullup_on = pullup_enable_r & `PULLUP_MASK & (~direction_control_r | open_drain); // [R3]

	// Readback seen by software
	wire [7:0] level_view = (pin_sync_r & (~direction_control_r | open_drain)) // [R4]
		| (pin_sync_r & `ALWAYS_READ_MASK); // [R5]

	// ==========================================================
	// AXI4-Lite write: address and data taken in either order
	// Readies fall with clk_en: a frozen block must not show a handshake it ignores
	wire write_go = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire write_ok = write_go & wlane_r;
	assign s_axi_awready = clk_en & ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = clk_en & ~w_held_r & ~s_axi_bvalid;

	// Registers sit at a byte address four times their index
	function reg_hit;
		input [11:0] idx;
		input [11:0] target;
		begin
			reg_hit = (idx == target);
		end
	endfunction

	function mapped;
		input [11:0] idx;
		begin
			mapped = reg_hit(idx, `ADDR_OUTPUT_LATCH) || reg_hit(idx, `ADDR_LEVEL_READBACK)
				|| reg_hit(idx, `ADDR_DIRECTION) || reg_hit(idx, `ADDR_PULLUP_ENABLE)
				|| reg_hit(idx, `ADDR_FUNCTION_SELECT) || reg_hit(idx, `ADDR_OUTPUT_TYPE);
		end
	endfunction

	// ==========================================================
	// Write decode
	// At most one strobe per accepted word; a cleared lane 0 writes nothing
	wire wr_latch = write_ok & reg_hit(awaddr_r, `ADDR_OUTPUT_LATCH);
	wire wr_dir = write_ok & reg_hit(awaddr_r, `ADDR_DIRECTION);
	wire wr_pullup = write_ok & reg_hit(awaddr_r, `ADDR_PULLUP_ENABLE);
	wire wr_func = write_ok & reg_hit(awaddr_r, `ADDR_FUNCTION_SELECT);
	wire wr_otype = write_ok & reg_hit(awaddr_r, `ADDR_OUTPUT_TYPE);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 8'h00;
			wlane_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr[13:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[7:0];
				wlane_r <= s_axi_wstrb[0];
			end
			if (write_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped index answers with an error and writes nothing
				s_axi_bresp <= mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register file: only byte lane 0 carries data; upper lanes are ignored
	always @(posedge aclk) begin
		if (!aresetn) begin
			output_latch_r <= `REG_RESET;
			direction_control_r <= `REG_RESET; // [R7]
			pullup_enable_r <= `REG_RESET;
			function_select_r <= `REG_RESET;
			output_type_select_r <= `REG_RESET;
		end else if (clk_en) begin
			if (wr_latch) begin
				output_latch_r <= wdata_r & `LATCH_MASK;
			end
			if (wr_dir) begin
				direction_control_r <= wdata_r & `DIR_MASK; // [R7]
			end
			if (wr_pullup) begin
				pullup_enable_r <= wdata_r & `PULLUP_MASK; // [R8]
			end
			if (wr_func) begin
				function_select_r <= wdata_r & `FUNC_MASK; // [R8]
			end
			if (wr_otype) begin
				output_type_select_r <= wdata_r & `OTYPE_MASK; // [R8] [R2]
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read
	wire [11:0] rd_idx = s_axi_araddr[13:2];
	assign s_axi_arready = clk_en & ~s_axi_rvalid;
	reg [7:0] read_val;
	always @* begin
		read_val = 8'h00;
		if (reg_hit(rd_idx, `ADDR_OUTPUT_LATCH))
			read_val = output_latch_r;
		else if (reg_hit(rd_idx, `ADDR_LEVEL_READBACK))
			read_val = level_view; // [R4] [R5]
		else if (reg_hit(rd_idx, `ADDR_DIRECTION))
			read_val = direction_control_r;
		else if (reg_hit(rd_idx, `ADDR_PULLUP_ENABLE))
			read_val = pullup_enable_r & `PULLUP_MASK; // [R8]
		else if (reg_hit(rd_idx, `ADDR_FUNCTION_SELECT))
			read_val = function_select_r & `FUNC_MASK; // [R8]
		else if (reg_hit(rd_idx, `ADDR_OUTPUT_TYPE))
			read_val = output_type_select_r & `OTYPE_MASK; // [R2] [R8]
	end

	// Data is captured as the address is taken, so rdata holds still until rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, read_val};
				s_axi_rresp <= mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
